// [rtl/sdram_ctrl_pkg.sv]
// sdram_ctrl_pkg: constants shared by the sdr sdram command controller.
// assumes one 50 MHz system clock shared by host, controller and memory.
package sdram_ctrl_pkg;
  localparam int address_width_param = 23;
  localparam int data_width_param = 32;
  localparam int MASK_W = data_width_param / 8;
  // host address map: column, row, bank, chip select
  localparam int COL_LSB = 0;
  localparam int COL_W = 8;
  localparam int ROW_LSB = 8;
  localparam int ROW_W = 12;
  localparam int BANK_LSB = 20;
  localparam int CS_BIT = 22;
  localparam int AP_BIT = 10;
  // host command codes
  localparam logic [2:0] HC_NOP = 3'h0;
  localparam logic [2:0] HC_READ = 3'h1;
  localparam logic [2:0] HC_WRITE = 3'h2;
  localparam logic [2:0] HC_REFRESH = 3'h3;
  localparam logic [2:0] HC_PRECHARGE = 3'h4;
  localparam logic [2:0] HC_LOAD_MODE = 3'h5;
  localparam logic [2:0] HC_LOAD_CONFIG = 3'h6;
  localparam logic [2:0] HC_LOAD_PERIOD = 3'h7;
  // memory bus commands as {row strobe, column strobe, write enable}
  localparam logic [2:0] MC_NOP = 3'h7;
  localparam logic [2:0] MC_ACT = 3'h3;
  localparam logic [2:0] MC_RD = 3'h5;
  localparam logic [2:0] MC_WR = 3'h4;
  localparam logic [2:0] MC_BT = 3'h6;
  localparam logic [2:0] MC_PCH = 3'h2;
  localparam logic [2:0] MC_ARF = 3'h1;
  localparam logic [2:0] MC_LMR = 3'h0;
  // configuration word fields
  localparam int CFG_CL_LSB = 0;
  localparam int CFG_RCD_LSB = 2;
  localparam int CFG_RRD_LSB = 4;
  localparam int CFG_PM_BIT = 8;
  localparam int CFG_BL_LSB = 9;
  // values after reset
  localparam logic [1:0] CL_RST = 2'h3;
  localparam logic [1:0] RCD_RST = 2'h3;
  localparam logic [3:0] RRD_RST = 4'h7;
  localparam logic [3:0] BL_RST = 4'h8;
  localparam logic [15:0] PERIOD_RST = 16'h0186;
  // read buffer
  localparam int FIFO_DEPTH = 16;
  localparam int BURST_MAX = 8;
endpackage

// [rtl/sdr_sdram_command_controller.sv]
// sdr_sdram_command_controller: host command port to sdr sdram bus,
// with a read data buffer. assumes host and memory share clk_sys_i.
//
// Summary of operation
// - memory commands encoded on row/column strobe and write enable.
// - a cycle with both chip selects high is a no-op.
// - a bank is activated with row and bank before read or write.
// - an open bank with another row is precharged, then reactivated.
// - first read word returns a cas latency after the read.
// - bursts run word by word up to the configured burst length.
// - auto refresh issued periodically from a 16-bit refresh counter.
// - all signals synchronous to one clock, outputs from registers.
// - address bit 10 picks all banks or one bank on precharge.
// - load mode drives the op-code on the memory address.
// - two-bit bank select goes with activate, read, write, precharge.
// - two separate active-low chip selects.
// - high mask bit blocks its byte; host masks go to memory masks.
// - three-bit host command codes from no-op to load period.
// - command, address and data captured on the next rising edge.
// - each accepted command acked for one clock as memory work starts.
// - no-op does nothing and leaves running accesses alone.
// - read is activate then read; data rcd+cl+2 clocks after ack.
// - page mode runs reads and writes without auto precharge.
// - write data first with command, rest from rcd-1 after ack.
// - config word: cl, rcd, refresh duration, page mode, burst.
// - load period takes 16 bits: clocks between auto refreshes.
// - load mode copies host address 11:0 onto memory address 11:0.
`timescale 1ns/10ps

module sync_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic load;
  logic pop;
  logic bypass;
  logic store;

  assign in_ready_o = count_reg != (AW+1)'(DEPTH);
  assign push = in_valid_i && in_ready_o;
  assign load = !out_valid_o || out_ready_i;
  assign pop = load && (count_reg != '0);
  // an empty buffer hands the word straight to the output stage when that stage can load
  assign bypass = load && (count_reg == '0) && push;
  assign store = push && !bypass;
  assign level_o = count_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (store)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (store)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (store && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !store)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (load)
    begin
      out_valid_o <= pop || bypass;
      if (pop)
      begin
        out_data_o <= mem_reg[rd_ptr_reg];
      end
      else if (bypass)
      begin
        out_data_o <= in_data_i;
      end
    end
  end
endmodule

module sdr_sdram_command_controller
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] cmd_i,
  input wire logic [22:0] addr_i,
  input wire logic [31:0] write_data_in_i,
  input wire logic [3:0] write_byte_mask_i,
  output logic command_ack_o,
  output logic [31:0] read_data_out_o,
  output logic read_data_valid_o,
  input wire logic read_data_ready_i,
  output logic [11:0] mem_address_out_o,
  output logic [1:0] mem_bank_o,
  output logic [1:0] mem_cs_n_o,
  output logic mem_cke_o,
  output logic mem_ras_n_o,
  output logic mem_cas_n_o,
  output logic mem_we_n_o,
  input wire logic [31:0] mem_dq_i,
  output logic [31:0] mem_dq_o,
  output logic mem_dq_oe_o,
  output logic [3:0] mem_dqm_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_PRE_WAIT, ST_ACT_WAIT, ST_BURST,
    ST_RECOVER} state_e;

  function automatic logic [1:0] bank_of(input logic [22:0] a);
    return a[sdram_ctrl_pkg::BANK_LSB +: 2];
  endfunction

  function automatic logic [12:0] tag_of(input logic [22:0] a);
    return {a[sdram_ctrl_pkg::CS_BIT],
      a[sdram_ctrl_pkg::ROW_LSB +: sdram_ctrl_pkg::ROW_W]};
  endfunction

  function automatic logic [1:0] cs_of(input logic [22:0] a);
    return a[sdram_ctrl_pkg::CS_BIT] ? 2'h1 : 2'h2;
  endfunction

  function automatic logic [3:0] dec1(input logic [3:0] x);
    return (x == 4'h0) ? 4'h0 : x - 4'h1;
  endfunction

  function automatic logic [1:0] eff(input logic [1:0] x);
    return (x == 2'h0) ? 2'h1 : x;
  endfunction

  state_e state_reg;
  logic [3:0] wait_reg;
  logic [3:0] burst_reg;
  logic op_write_reg;
  logic op_ap_reg;
  logic [22:0] addr_hold_reg;
  logic [31:0] wdata0_reg;
  logic [3:0] mask0_reg;
  logic [1:0] cl_reg;
  logic [1:0] rcd_reg;
  logic [3:0] rrd_reg;
  logic pm_reg;
  logic [3:0] bl_reg;
  logic [15:0] period_reg;
  logic [15:0] ref_cnt_reg;
  logic ref_due_reg;
  logic [3:0] open_reg;
  logic [12:0] row_reg [4];
  logic [2:0] mcmd_reg;
  logic [31:0] wstage_reg;
  logic [3:0] mstage_reg;
  logic [2:0] rd_pipe_reg;
  logic [31:0] cap_reg;
  logic cap_valid_reg;
  logic fifo_in_ready;
  logic [4:0] fifo_level;
  logic [22:0] cur_addr;
  logic [1:0] cur_bank;
  logic idle;
  logic ref_pch;
  logic ref_arf;
  logic rd_room;
  logic host_go;
  logic acc_go;
  logic hit;
  logic iss_act;
  logic iss_pch_bank;
  logic iss_pch_all;
  logic iss_arf;
  logic iss_lmr;
  logic iss_rw;
  logic rd_live;

  assign mem_ras_n_o = mcmd_reg[2];
  assign mem_cas_n_o = mcmd_reg[1];
  assign mem_we_n_o = mcmd_reg[0];

  assign idle = state_reg == ST_IDLE;
  assign cur_addr = idle ? addr_i : addr_hold_reg;
  assign cur_bank = bank_of(cur_addr);
  assign hit = open_reg[cur_bank] &&
    (row_reg[cur_bank] == tag_of(cur_addr));
  // refresh wins over a waiting host command, which simply is not acked
  assign ref_pch = idle && ref_due_reg && (open_reg != 4'h0);
  assign ref_arf = idle && ref_due_reg && (open_reg == 4'h0);
  // a read starts only when the buffer can take a whole burst
  assign rd_room = fifo_in_ready && (fifo_level <=
    5'(sdram_ctrl_pkg::FIFO_DEPTH - sdram_ctrl_pkg::BURST_MAX));
  // the host may still hold its command in the ack cycle: take it once
  assign host_go = idle && !ref_due_reg && !command_ack_o &&
    (cmd_i != sdram_ctrl_pkg::HC_NOP) &&
    ((cmd_i != sdram_ctrl_pkg::HC_READ) || rd_room);
  assign acc_go = host_go && ((cmd_i == sdram_ctrl_pkg::HC_READ) ||
    (cmd_i == sdram_ctrl_pkg::HC_WRITE));
  assign iss_pch_bank = acc_go && open_reg[cur_bank] && !hit;
  assign iss_act = (acc_go && !open_reg[cur_bank]) ||
    ((state_reg == ST_PRE_WAIT) && (wait_reg == 4'h0));
  assign iss_rw = (state_reg == ST_ACT_WAIT) && (wait_reg == 4'h0);
  assign iss_pch_all = ref_pch ||
    (host_go && (cmd_i == sdram_ctrl_pkg::HC_PRECHARGE));
  assign iss_arf = ref_arf ||
    (host_go && (cmd_i == sdram_ctrl_pkg::HC_REFRESH));
  assign iss_lmr = host_go && (cmd_i == sdram_ctrl_pkg::HC_LOAD_MODE);
  assign rd_live = (state_reg == ST_BURST) && !op_write_reg;

  // sequencer; a hit in page mode waits rcd too, so its latency matches a closed bank
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      wait_reg <= 4'h0;
      burst_reg <= 4'h0;
      op_write_reg <= 1'b0;
      op_ap_reg <= 1'b1;
      addr_hold_reg <= '0;
      wdata0_reg <= '0;
      mask0_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (ref_pch || iss_pch_all || iss_lmr)
          begin
            state_reg <= ST_RECOVER;
            wait_reg <= dec1({2'h0, rcd_reg});
          end
          else if (iss_arf)
          begin
            state_reg <= ST_RECOVER;
            wait_reg <= dec1(rrd_reg);
          end
          else if (acc_go)
          begin
            state_reg <= iss_pch_bank ? ST_PRE_WAIT : ST_ACT_WAIT;
            wait_reg <= dec1({2'h0, rcd_reg});
            op_write_reg <= cmd_i == sdram_ctrl_pkg::HC_WRITE;
            op_ap_reg <= !pm_reg;
            addr_hold_reg <= addr_i;
            wdata0_reg <= write_data_in_i;
            mask0_reg <= write_byte_mask_i;
          end
        end
        ST_PRE_WAIT:
        begin
          if (wait_reg == 4'h0)
          begin
            state_reg <= ST_ACT_WAIT;
            wait_reg <= dec1({2'h0, rcd_reg});
          end
          else
          begin
            wait_reg <= wait_reg - 4'h1;
          end
        end
        ST_ACT_WAIT:
        begin
          if (wait_reg == 4'h0)
          begin
            state_reg <= ST_BURST;
            burst_reg <= dec1(bl_reg);
          end
          else
          begin
            wait_reg <= wait_reg - 4'h1;
          end
        end
        ST_BURST:
        begin
          if (burst_reg == 4'h0)
          begin
            state_reg <= ST_RECOVER;
            wait_reg <= op_write_reg ? dec1({2'h0, rcd_reg}) :
              {2'h0, cl_reg} + {2'h0, rcd_reg};
          end
          else
          begin
            burst_reg <= burst_reg - 4'h1;
          end
        end
        ST_RECOVER:
        begin
          if (wait_reg == 4'h0)
          begin
            state_reg <= ST_IDLE;
          end
          else
          begin
            wait_reg <= wait_reg - 4'h1;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // memory command bus; deselect is the idle no-op
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mcmd_reg <= sdram_ctrl_pkg::MC_NOP;
      mem_cs_n_o <= 2'h3;
      mem_address_out_o <= '0;
      mem_bank_o <= 2'h0;
      mem_cke_o <= 1'b0;
      command_ack_o <= 1'b0;
    end
    else
    begin
      mem_cke_o <= 1'b1;
      command_ack_o <= host_go;
      mcmd_reg <= sdram_ctrl_pkg::MC_NOP;
      mem_cs_n_o <= 2'h3;
      if (iss_act)
      begin
        mcmd_reg <= sdram_ctrl_pkg::MC_ACT;
        mem_cs_n_o <= cs_of(cur_addr);
        mem_address_out_o <= cur_addr[sdram_ctrl_pkg::ROW_LSB +: 12];
        mem_bank_o <= cur_bank;
      end
      else if (iss_pch_bank)
      begin
        mcmd_reg <= sdram_ctrl_pkg::MC_PCH;
        mem_cs_n_o <= cs_of(cur_addr);
        mem_address_out_o <= 12'h000;
        mem_bank_o <= cur_bank;
      end
      else if (iss_rw)
      begin
        mcmd_reg <= op_write_reg ? sdram_ctrl_pkg::MC_WR :
          sdram_ctrl_pkg::MC_RD;
        mem_cs_n_o <= cs_of(cur_addr);
        mem_address_out_o <= 12'(addr_hold_reg[sdram_ctrl_pkg::COL_LSB +:
          sdram_ctrl_pkg::COL_W]);
        mem_address_out_o[sdram_ctrl_pkg::AP_BIT] <= op_ap_reg;
        mem_bank_o <= cur_bank;
      end
      else if (iss_pch_all)
      begin
        mcmd_reg <= sdram_ctrl_pkg::MC_PCH;
        mem_cs_n_o <= 2'h0;
        mem_address_out_o <= 12'h400;
      end
      else if (iss_arf)
      begin
        mcmd_reg <= sdram_ctrl_pkg::MC_ARF;
        mem_cs_n_o <= 2'h0;
      end
      else if (iss_lmr)
      begin
        mcmd_reg <= sdram_ctrl_pkg::MC_LMR;
        mem_cs_n_o <= 2'h0;
        mem_address_out_o <= addr_i[11:0];
        mem_bank_o <= 2'h0;
      end
    end
  end

  // open row per bank; auto precharge closes it with the read or write
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      open_reg <= 4'h0;
      for (int i = 0; i < 4; i++)
      begin
        row_reg[i] <= '0;
      end
    end
    else if (iss_pch_all)
    begin
      open_reg <= 4'h0;
    end
    else if (iss_pch_bank || (iss_rw && op_ap_reg))
    begin
      open_reg[cur_bank] <= 1'b0;
    end
    else if (iss_act)
    begin
      open_reg[cur_bank] <= 1'b1;
      row_reg[cur_bank] <= tag_of(cur_addr);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cl_reg <= sdram_ctrl_pkg::CL_RST;
      rcd_reg <= sdram_ctrl_pkg::RCD_RST;
      rrd_reg <= sdram_ctrl_pkg::RRD_RST;
      pm_reg <= 1'b0;
      bl_reg <= sdram_ctrl_pkg::BL_RST;
      period_reg <= sdram_ctrl_pkg::PERIOD_RST;
    end
    else if (host_go && (cmd_i == sdram_ctrl_pkg::HC_LOAD_CONFIG))
    begin
      cl_reg <= addr_i[sdram_ctrl_pkg::CFG_CL_LSB +: 2];
      rcd_reg <= addr_i[sdram_ctrl_pkg::CFG_RCD_LSB +: 2];
      rrd_reg <= addr_i[sdram_ctrl_pkg::CFG_RRD_LSB +: 4];
      pm_reg <= addr_i[sdram_ctrl_pkg::CFG_PM_BIT];
      bl_reg <= addr_i[sdram_ctrl_pkg::CFG_BL_LSB +: 4];
    end
    else if (host_go && (cmd_i == sdram_ctrl_pkg::HC_LOAD_PERIOD))
    begin
      period_reg <= addr_i[15:0];
    end
  end

  // a period of zero stops auto refresh; a new due beats the clear
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ref_cnt_reg <= 16'h0000;
      ref_due_reg <= 1'b0;
    end
    else
    begin
      if ((period_reg != 16'h0000) &&
          (ref_cnt_reg >= period_reg - 16'h0001))
      begin
        ref_cnt_reg <= 16'h0000;
        ref_due_reg <= 1'b1;
      end
      else
      begin
        ref_cnt_reg <= ref_cnt_reg + 16'h0001;
        if (ref_arf)
        begin
          ref_due_reg <= 1'b0;
        end
      end
    end
  end

  // write path: two stages so host word k lands at rcd+k after the ack
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wstage_reg <= '0;
      mstage_reg <= '0;
      mem_dq_o <= '0;
      mem_dq_oe_o <= 1'b0;
      mem_dqm_o <= '0;
    end
    else
    begin
      wstage_reg <= write_data_in_i;
      mstage_reg <= write_byte_mask_i;
      if (iss_rw && op_write_reg)
      begin
        mem_dq_o <= wdata0_reg;
        mem_dqm_o <= mask0_reg;
        mem_dq_oe_o <= 1'b1;
      end
      else if ((state_reg == ST_BURST) && op_write_reg &&
               (burst_reg != 4'h0))
      begin
        mem_dq_o <= wstage_reg;
        mem_dqm_o <= mstage_reg;
        mem_dq_oe_o <= 1'b1;
      end
      else
      begin
        mem_dqm_o <= 4'h0;
        mem_dq_oe_o <= 1'b0;
      end
    end
  end

  // read path: words are caught a cas latency after each burst slot
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_pipe_reg <= 3'h0;
      cap_reg <= '0;
      cap_valid_reg <= 1'b0;
    end
    else
    begin
      rd_pipe_reg <= {rd_pipe_reg[1:0], rd_live};
      cap_valid_reg <= rd_pipe_reg[eff(cl_reg) - 2'h1];
      cap_reg <= mem_dq_i;
    end
  end

  sync_fifo #(
    .WIDTH(sdram_ctrl_pkg::data_width_param),
    .DEPTH(sdram_ctrl_pkg::FIFO_DEPTH)
  ) u_read_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(cap_valid_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(cap_reg),
    .out_valid_o(read_data_valid_o),
    .out_ready_i(read_data_ready_i),
    .out_data_o(read_data_out_o),
    .level_o(fifo_level)
  );

  // helpers watched only by the checks below
  logic [5:0] since_ack_reg;
  logic lat_arm_reg;
  logic [3:0] burst_seen_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      since_ack_reg <= 6'h00;
      lat_arm_reg <= 1'b0;
      burst_seen_reg <= 4'h0;
    end
    else
    begin
      burst_seen_reg <= (state_reg == ST_BURST) ?
        burst_seen_reg + 4'h1 : 4'h0;
      if (host_go)
      begin
        since_ack_reg <= 6'h00;
        lat_arm_reg <= (cmd_i == sdram_ctrl_pkg::HC_READ) && !iss_pch_bank;
      end
      else if (since_ack_reg != 6'h3f)
      begin
        since_ack_reg <= since_ack_reg + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_accept;
    host_go;
  endsequence
  sequence s_ack_pulse;
    command_ack_o ##1 !command_ack_o;
  endsequence
  property p_ack_once;
    s_accept |=> s_ack_pulse;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack is not a single-cycle pulse");

  property p_nop_quiet;
    idle && !ref_due_reg && (cmd_i == sdram_ctrl_pkg::HC_NOP)
      |=> !command_ack_o;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("no-op was acknowledged");

  property p_act_first;
    command_ack_o && !op_ap_reg == pm_reg && (state_reg == ST_ACT_WAIT)
      && (mcmd_reg != sdram_ctrl_pkg::MC_NOP)
      |-> mcmd_reg == sdram_ctrl_pkg::MC_ACT && mem_cs_n_o != 2'h3;
  endproperty
  a_act_first: assert property (p_act_first)
    else $error("access did not start with activate");

  // auto precharge clears the open flag on the edge that issues the column
  property p_rw_open;
    (mem_cs_n_o != 2'h3) && ((mcmd_reg == sdram_ctrl_pkg::MC_RD) ||
      (mcmd_reg == sdram_ctrl_pkg::MC_WR))
      |-> $past(open_reg[cur_bank]) && (mem_bank_o == cur_bank) &&
      (row_reg[cur_bank] == tag_of(addr_hold_reg));
  endproperty
  a_rw_open: assert property (p_rw_open)
    else $error("read or write to a bank without its row open");

  property p_pch_all;
    host_go && (cmd_i == sdram_ctrl_pkg::HC_PRECHARGE)
      |=> (mcmd_reg == sdram_ctrl_pkg::MC_PCH) && mem_address_out_o[10]
      && (mem_cs_n_o == 2'h0);
  endproperty
  a_pch_all: assert property (p_pch_all)
    else $error("precharge all without address bit 10");

  property p_lmr_code;
    iss_lmr |=> (mcmd_reg == sdram_ctrl_pkg::MC_LMR) &&
      (mem_address_out_o == $past(addr_i[11:0]));
  endproperty
  a_lmr_code: assert property (p_lmr_code)
    else $error("mode op-code not on memory address");

  property p_ref_issue;
    ref_arf |=> (mcmd_reg == sdram_ctrl_pkg::MC_ARF) && !ref_due_reg
      ##1 (state_reg == ST_RECOVER) || (state_reg == ST_IDLE);
  endproperty
  a_ref_issue: assert property (p_ref_issue)
    else $error("due refresh not issued");

  property p_rd_latency;
    $rose(cap_valid_reg) && lat_arm_reg |-> since_ack_reg ==
      6'(eff(rcd_reg)) + 6'(eff(cl_reg)) + 6'h01;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read data late or early");

  property p_burst_len;
    (state_reg == ST_BURST) && (burst_reg == 4'h0)
      |-> burst_seen_reg == dec1(bl_reg);
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length differs from setting");

  property p_wr_mask;
    iss_rw && op_write_reg |=> mem_dq_oe_o && (mem_dqm_o == mask0_reg)
      && (mcmd_reg == sdram_ctrl_pkg::MC_WR);
  endproperty
  a_wr_mask: assert property (p_wr_mask)
    else $error("first write mask not forwarded");

  property p_cfg;
    host_go && (cmd_i == sdram_ctrl_pkg::HC_LOAD_CONFIG)
      |=> (cl_reg == $past(addr_i[1:0])) && (bl_reg == $past(addr_i[12:9]));
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("configuration word not loaded");
endmodule

// [test/sdram_mem_model.sv]
// sdram_mem_model: behavioural sdr sdram, fixed latency and burst.
// assumes the controller's reset latency and burst and one shared clock.
`timescale 1ns/10ps
module sdram_mem_model
#(
  parameter int CL = 3,
  parameter int BL = 8
)
(
  input wire logic clk_sys_i,
  input wire logic [11:0] addr_i,
  input wire logic [1:0] bank_i,
  input wire logic [1:0] cs_n_i,
  input wire logic [2:0] cmd_i,
  input wire logic [31:0] dq_i,
  input wire logic [3:0] dqm_i,
  output logic [31:0] dq_o
);
  logic [31:0] mem_reg [0:1023];
  logic [9:0] wp = 10'h0;
  logic [9:0] rp = 10'h0;
  int wl = 0;
  int rl = 0;
  int rd = 0;
  initial
  begin
    dq_o = 32'h0;
    foreach (mem_reg[i])
      mem_reg[i] = 32'h0;
  end
  always @(posedge clk_sys_i)
  begin
    if (cs_n_i != 2'h3 && cmd_i == 3'h4)
    begin
      wp = {bank_i, addr_i[7:0]};
      wl = BL;
    end
    if (wl > 0)
    begin
      for (int b = 0; b < 4; b++)
        if (!dqm_i[b])
          mem_reg[wp][8*b +: 8] = dq_i[8*b +: 8];
      wp = wp + 10'h1;
      wl = wl - 1;
    end
    if (cs_n_i != 2'h3 && cmd_i == 3'h5)
    begin
      rp = {bank_i, addr_i[7:0]};
      rl = BL;
      rd = CL - 1;
    end
    else if (rd > 1)
      rd = rd - 1;
    else if (rl > 0)
    begin
      dq_o <= mem_reg[rp];
      rp = rp + 10'h1;
      rl = rl - 1;
    end
    else
      dq_o <= ~dq_o; // released bus must not hold the last word
  end
endmodule

// [test/sdr_sdram_command_controller_tb_top.sv]
// sdr_sdram_command_controller_tb_top: command sequences with checks.
// assumes reset configuration: cl 3, rcd 3, burst 8, page mode off.
`timescale 1ns/10ps
module sdr_sdram_command_controller_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] cmd = 3'h0;
  logic [22:0] addr = 23'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wmask = 4'h0;
  logic ack, rvalid, cke, ras_n, cas_n, we_n, oe;
  logic [31:0] rdata, dq_to_mem, dq_from_mem;
  logic [11:0] maddr, bus_addr;
  logic [1:0] bank, cs_n, bus_cs;
  logic [2:0] bus_cmd;
  logic [3:0] dqm;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  sdr_sdram_command_controller i_sdr_sdram_command_controller (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_i(cmd), .addr_i(addr),
    .write_data_in_i(wdata), .write_byte_mask_i(wmask),
    .command_ack_o(ack), .read_data_out_o(rdata),
    .read_data_valid_o(rvalid), .read_data_ready_i(1'b1),
    .mem_address_out_o(maddr), .mem_bank_o(bank), .mem_cs_n_o(cs_n),
    .mem_cke_o(cke), .mem_ras_n_o(ras_n), .mem_cas_n_o(cas_n),
    .mem_we_n_o(we_n), .mem_dq_i(dq_from_mem), .mem_dq_o(dq_to_mem),
    .mem_dq_oe_o(oe), .mem_dqm_o(dqm));
  sdram_mem_model i_sdram_mem_model (
    .clk_sys_i(clk_sys_i), .addr_i(maddr), .bank_i(bank), .cs_n_i(cs_n),
    .cmd_i({ras_n, cas_n, we_n}), .dq_i(dq_to_mem), .dqm_i(dqm),
    .dq_o(dq_from_mem));
  initial
  begin
    forever
      #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits for the ack, keeps the bus lines seen during the ack cycle
  task automatic issue(input logic [2:0] c, input logic [22:0] a);
    n = 0;
    cmd <= c;
    addr <= a;
    do
      @(posedge clk_sys_i);
    while (ack !== 1'b1 && ++n < 400);
    if (n >= 400)
      chk(32'h1, 32'h0);
    if (n >= 400)
      finish_test();
    cmd <= sdram_ctrl_pkg::HC_NOP;
    bus_cmd = {ras_n, cas_n, we_n};
    bus_addr = maddr;
    bus_cs = cs_n;
    @(posedge clk_sys_i);
    chk(32'(ack), 32'h0);
  endtask
  task automatic wait_arf();
    n = 0;
    do
      @(posedge clk_sys_i);
    while (!(cs_n === 2'h0 && {ras_n, cas_n, we_n} === 3'h1) && ++n < 300);
    if (n >= 300)
      chk(32'h1, 32'h0);
    if (n >= 300)
      finish_test();
  endtask
  initial
  begin
    repeat (20)
      @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk(32'({cke, cs_n, ras_n, cas_n, we_n}), 32'h3f);
    issue(sdram_ctrl_pkg::HC_PRECHARGE, 23'h0);
    chk(32'({bus_cs, bus_cmd, bus_addr[10]}), 32'h05);
    issue(sdram_ctrl_pkg::HC_LOAD_MODE, 23'h000033);
    chk(32'({bus_cmd, bus_addr}), 32'h033);
    issue(sdram_ctrl_pkg::HC_REFRESH, 23'h0);
    chk(32'({bus_cs, bus_cmd}), 32'h01);
    issue(sdram_ctrl_pkg::HC_LOAD_CONFIG, 23'h00107f);
    chk(32'({bus_cs, bus_cmd}), 32'h1f);
    wdata <= 32'h10000000;
    issue(sdram_ctrl_pkg::HC_WRITE, 23'h012345);
    chk(32'({bus_cs, bus_cmd, bus_addr}), 32'h13123);
    for (int k = 1; k < 8; k++)
    begin
      wdata <= 32'h10000000 + k;
      wmask <= (k == 2) ? 4'h1 : 4'h0;
      @(posedge clk_sys_i);
    end
    wmask <= 4'h0;
    issue(sdram_ctrl_pkg::HC_READ, 23'h012345);
    n = 1;
    while (rvalid !== 1'b1 && n < 60)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(32'(n), 32'h8);
    for (int k = 0; k < 8; k++)
    begin
      chk(rdata, (k == 2) ? 32'h10000000 : 32'h10000000 + k);
      @(posedge clk_sys_i);
    end
    // page mode: a second read of the same row needs no activate
    issue(sdram_ctrl_pkg::HC_LOAD_CONFIG, 23'h00117f);
    issue(sdram_ctrl_pkg::HC_READ, 23'h012345);
    issue(sdram_ctrl_pkg::HC_READ, 23'h012345);
    chk(32'({bus_cs, bus_cmd}), 32'h1f);
    issue(sdram_ctrl_pkg::HC_PRECHARGE, 23'h0);
    issue(sdram_ctrl_pkg::HC_LOAD_PERIOD, 23'h000040);
    wait_arf();
    wait_arf();
    chk(32'(n + 1), 32'h40);
    finish_test();
  end
endmodule
